/* rtl/lem_monitor.sv */
// line event supervision: crossing timeout, period, dip, peaks and interrupt flags
//
// What this block does
// - 12-bit crossing timeout counter decrements once every 128 clocks.
// - each voltage zero crossing reloads the counter from the programmed value.
// - programmed timeout value is 0xfff after reset.
// - counter reaching zero drives dip output low unless dip output disabled.
// - timeout sets its flag always; interrupt only when its enable is set.
// - timeout value is read/write at address 1Dh, 128 clocks per count.
// - 16-bit line period register, updated each period, top bit zero.
// - period count advances once every eight clocks.
// - supply low makes block inactive and holds dip output low.
// - dip cycle setting N of 2 or more asserts dip after N-1 full low cycles.
// - dip sets flag, interrupt if enabled, output only if not disabled.
// - dip output released once voltage magnitude reaches the dip threshold.
// - dip compare uses top byte of doubled filtered voltage magnitude.
// - peak thresholds compared with top byte of doubled magnitudes, both channels.
// - peak exceed sets its flag, interrupt only if enabled.
// - 16-bit interrupt enable register at address 0x0A.
// - 24-bit maximum records per channel, voltage record holds twice magnitude.
// - read of the clearing alias returns a record then zeroes it.
// - events set flags regardless of enables; irq low on any enabled flag.
// - read at 0x0C returns and clears flags; irq goes high.
// - event during clearing read is kept and shows after the transfer.
// - zero crossing output follows voltage sign; edges are the crossing events.
// - irq held high from command end until last data bit shifted.
`timescale 1ns/1ps
`default_nettype none

module lem_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_low_i,
  input wire logic [15:0] volt_filt_i,
  input wire logic volt_filt_valid_i,
  input wire logic [23:0] volt_sample_i,
  input wire logic volt_sample_valid_i,
  input wire logic [23:0] curr_sample_i,
  input wire logic curr_sample_valid_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic [23:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic reg_xfer_done_i,
  output logic [23:0] reg_rdata_o,
  output logic irq_n_o,
  output logic dip_n_o,
  output logic zero_cross_o,
  output logic inactive_o
);

  lem_pkg::lem_state_t st;
  lem_pkg::lem_state_t next_st;

  // magnitude of a signed 24-bit sample; most negative code saturates
  function automatic logic [23:0] lem_abs24(input logic [23:0] v);
    logic [23:0] m;
    m = v[23] ? (~v + 24'h000001) : v;
    if (m[23]) begin
      m = 24'h7fffff;
    end
    return m;
  endfunction

  // top byte of a magnitude after doubling
  function automatic logic [7:0] lem_top_doubled(input logic [23:0] m);
    logic [23:0] d;
    d = {m[22:0], 1'b0};
    return d[23:16];
  endfunction

  logic [15:0] volt_filt_abs;
  logic [7:0] dip_byte;
  logic filt_below;
  logic zx_rise;
  logic zx_fall;
  logic [23:0] vmag;
  logic [23:0] vmag2;
  logic [23:0] imag;
  logic v_upd;
  logic i_upd;
  logic [15:0] ev;
  logic [7:0] run_inc;
  logic rd_hit;
  logic wr_hit;

  always_comb begin
    next_st = st;
    ev = 16'h0000;
    run_inc = 8'h00;
    rd_hit = reg_rd_i;
    wr_hit = reg_wr_i;

    // supply low input: three flops, a change counts when last two agree
    next_st.sup_sync = {st.sup_sync[1:0], supply_low_i};
    if (st.sup_sync[1] == st.sup_sync[2]) begin
      next_st.sup_low = st.sup_sync[2];
    end

    // crossing events from filtered voltage sign
    zx_rise = volt_filt_valid_i && !volt_filt_i[15] && !st.zx;
    zx_fall = volt_filt_valid_i && volt_filt_i[15] && st.zx;
    if (zx_rise) begin
      next_st.zx = 1'b1;
    end else if (zx_fall) begin
      next_st.zx = 1'b0;
    end
    if (zx_rise || zx_fall) begin
      ev[lem_pkg::FLAG_ZX_BIT] = 1'b1;
    end

    next_st.tmo_pre = st.tmo_pre + 7'h01;
    if (st.tmo_pre == lem_pkg::TMO_PRESCALE_LAST && st.tmo_cnt != 12'h000) begin
      next_st.tmo_cnt = st.tmo_cnt - 12'h001;
      if (st.tmo_cnt == 12'h001) begin
        next_st.tmo_active = 1'b1;
        ev[lem_pkg::FLAG_TMO_BIT] = 1'b1;
      end
    end
    if (zx_rise || zx_fall) begin
      next_st.tmo_cnt = st.tmo_full;
      next_st.tmo_pre = 7'h00;
      next_st.tmo_active = 1'b0;
    end

    next_st.per_pre = st.per_pre + 3'h1;
    if (st.per_pre == lem_pkg::PERIOD_PRESCALE_LAST && st.per_cnt != lem_pkg::PERIOD_MAX) begin
      next_st.per_cnt = st.per_cnt + 16'h0001;
    end
    // latch once per period, top bit stays zero by saturation
    if (zx_rise) begin
      next_st.period = st.per_cnt;
      next_st.per_cnt = 16'h0000;
      next_st.per_pre = 3'h0;
    end

    // dip compare on doubled top byte of filtered magnitude
    volt_filt_abs = volt_filt_i[15] ? (~volt_filt_i + 16'h0001) : volt_filt_i;
    dip_byte = volt_filt_abs[14:7];
    filt_below = st.dip_lvl > dip_byte;
    if (volt_filt_valid_i && !filt_below) begin
      next_st.cyc_above = 1'b1;
      next_st.dip_active = 1'b0;
    end
    // count full line cycles spent below the threshold
    if (zx_rise) begin
      next_st.cyc_above = 1'b0;
      if (st.cyc_above) begin
        next_st.dip_run = 8'h00;
      end else begin
        run_inc = (st.dip_run == 8'hff) ? st.dip_run : st.dip_run + 8'h01;
        next_st.dip_run = run_inc;
        if (st.dip_cyc >= lem_pkg::DIP_CYC_MIN && run_inc == st.dip_cyc - 8'h01) begin
          next_st.dip_active = 1'b1;
          ev[lem_pkg::FLAG_DIP_BIT] = 1'b1;
        end
      end
    end

    vmag = lem_abs24(volt_sample_i);
    vmag2 = {vmag[22:0], 1'b0};
    imag = lem_abs24(curr_sample_i);
    if (volt_sample_valid_i && lem_top_doubled(vmag) > st.vpk_lvl) begin
      ev[lem_pkg::FLAG_VPK_BIT] = 1'b1;
    end
    if (curr_sample_valid_i && lem_top_doubled(imag) > st.ipk_lvl) begin
      ev[lem_pkg::FLAG_IPK_BIT] = 1'b1;
    end
    v_upd = volt_sample_valid_i && vmag2 > st.vmax;
    i_upd = curr_sample_valid_i && imag > st.imax;

    // register reads: data is captured at the command
    if (rd_hit) begin
      if (reg_addr_i == lem_pkg::ADDR_MODE) begin
        next_st.rdata = {23'h000000, st.dip_dis};
      end else if (reg_addr_i == lem_pkg::ADDR_IRQ_EN) begin
        next_st.rdata = {8'h00, st.irq_en};
      end else if (reg_addr_i == lem_pkg::ADDR_STATUS) begin
        next_st.rdata = {8'h00, st.flags};
      end else if (reg_addr_i == lem_pkg::ADDR_STATUS_CLR) begin
        next_st.rdata = {8'h00, st.flags};
      end else if (reg_addr_i == lem_pkg::ADDR_TMO) begin
        next_st.rdata = {12'h000, st.tmo_full};
      end else if (reg_addr_i == lem_pkg::ADDR_DIP_LVL) begin
        next_st.rdata = {16'h0000, st.dip_lvl};
      end else if (reg_addr_i == lem_pkg::ADDR_DIP_CYC) begin
        next_st.rdata = {16'h0000, st.dip_cyc};
      end else if (reg_addr_i == lem_pkg::ADDR_IPK_LVL) begin
        next_st.rdata = {16'h0000, st.ipk_lvl};
      end else if (reg_addr_i == lem_pkg::ADDR_VPK_LVL) begin
        next_st.rdata = {16'h0000, st.vpk_lvl};
      end else if (reg_addr_i == lem_pkg::ADDR_IMAX || reg_addr_i == lem_pkg::ADDR_IMAX_CLR) begin
        next_st.rdata = st.imax;
      end else if (reg_addr_i == lem_pkg::ADDR_VMAX || reg_addr_i == lem_pkg::ADDR_VMAX_CLR) begin
        next_st.rdata = st.vmax;
      end else if (reg_addr_i == lem_pkg::ADDR_PERIOD) begin
        next_st.rdata = {8'h00, st.period};
      end else begin
        next_st.rdata = 24'h000000;
      end
    end

    // clearing aliases zero the record; a new larger sample still wins
    if (rd_hit && reg_addr_i == lem_pkg::ADDR_VMAX_CLR) begin
      next_st.vmax = 24'h000000;
    end
    if (rd_hit && reg_addr_i == lem_pkg::ADDR_IMAX_CLR) begin
      next_st.imax = 24'h000000;
    end
    if (v_upd) begin
      next_st.vmax = vmag2;
    end
    if (i_upd) begin
      next_st.imax = imag;
    end

    // clearing read empties the flags and raises irq
    // events of the same cycle survive the clear
    if (rd_hit && reg_addr_i == lem_pkg::ADDR_STATUS_CLR) begin
      next_st.flags = ev;
      next_st.irq_hold = 1'b1;
    end else begin
      next_st.flags = st.flags | ev;
    end
    // hold ends with the last data bit
    if (reg_xfer_done_i) begin
      next_st.irq_hold = 1'b0;
    end

    // register writes
    if (wr_hit) begin
      if (reg_addr_i == lem_pkg::ADDR_MODE) begin
        next_st.dip_dis = reg_wdata_i[lem_pkg::MODE_DIP_DIS_BIT];
      end else if (reg_addr_i == lem_pkg::ADDR_IRQ_EN) begin
        next_st.irq_en = reg_wdata_i[15:0];
      end else if (reg_addr_i == lem_pkg::ADDR_TMO) begin
        next_st.tmo_full = reg_wdata_i[11:0];
      end else if (reg_addr_i == lem_pkg::ADDR_DIP_LVL) begin
        next_st.dip_lvl = reg_wdata_i[7:0];
      end else if (reg_addr_i == lem_pkg::ADDR_DIP_CYC) begin
        next_st.dip_cyc = reg_wdata_i[7:0];
      end else if (reg_addr_i == lem_pkg::ADDR_IPK_LVL) begin
        next_st.ipk_lvl = reg_wdata_i[7:0];
      end else if (reg_addr_i == lem_pkg::ADDR_VPK_LVL) begin
        next_st.vpk_lvl = reg_wdata_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.tmo_full <= lem_pkg::TMO_RESET;
      st.tmo_cnt <= lem_pkg::TMO_RESET;
      st.irq_en <= lem_pkg::IRQ_EN_RESET;
      st.dip_lvl <= lem_pkg::DIP_LVL_RESET;
      st.dip_cyc <= lem_pkg::DIP_CYC_RESET;
      st.vpk_lvl <= lem_pkg::PK_LVL_RESET;
      st.ipk_lvl <= lem_pkg::PK_LVL_RESET;
      // no cycle seen yet counts as above, so no dip before a real cycle
      st.cyc_above <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign zero_cross_o = st.zx;
  assign inactive_o = st.sup_low;
  // supply low pulls dip low; disable gates dip and timeout
  assign dip_n_o = !(st.sup_low || (!st.dip_dis && (st.dip_active || st.tmo_active)));
  // any enabled flag pulls irq low; held high during clearing read
  assign irq_n_o = st.irq_hold || !(|(st.flags & st.irq_en));

endmodule

`default_nettype wire

/* rtl/lem_pkg.sv */
// constants and state layout for the line event monitor
package lem_pkg;

  // register addresses on the register access port
  localparam logic [5:0] ADDR_MODE = 6'h09;
  localparam logic [5:0] ADDR_IRQ_EN = 6'h0a;
  localparam logic [5:0] ADDR_STATUS = 6'h0b;
  localparam logic [5:0] ADDR_STATUS_CLR = 6'h0c;
  localparam logic [5:0] ADDR_TMO = 6'h1d;
  localparam logic [5:0] ADDR_DIP_LVL = 6'h1e;
  localparam logic [5:0] ADDR_DIP_CYC = 6'h1f;
  localparam logic [5:0] ADDR_IPK_LVL = 6'h20;
  localparam logic [5:0] ADDR_VPK_LVL = 6'h21;
  localparam logic [5:0] ADDR_IMAX = 6'h22;
  localparam logic [5:0] ADDR_IMAX_CLR = 6'h23;
  localparam logic [5:0] ADDR_VMAX = 6'h24;
  localparam logic [5:0] ADDR_VMAX_CLR = 6'h25;
  localparam logic [5:0] ADDR_PERIOD = 6'h26;

  // field positions
  localparam int MODE_DIP_DIS_BIT = 0;
  localparam int FLAG_DIP_BIT = 1;
  localparam int FLAG_TMO_BIT = 3;
  localparam int FLAG_ZX_BIT = 4;
  localparam int FLAG_IPK_BIT = 8;
  localparam int FLAG_VPK_BIT = 9;

  // values after reset
  localparam logic [11:0] TMO_RESET = 12'hfff;
  localparam logic [7:0] DIP_LVL_RESET = 8'h00;
  localparam logic [7:0] DIP_CYC_RESET = 8'hff;
  localparam logic [7:0] PK_LVL_RESET = 8'hff;
  localparam logic [15:0] IRQ_EN_RESET = 16'h0000;

  // cycle counts
  localparam logic [6:0] TMO_PRESCALE_LAST = 7'h7f;
  localparam logic [2:0] PERIOD_PRESCALE_LAST = 3'h7;
  localparam logic [15:0] PERIOD_MAX = 16'h7fff;
  localparam logic [7:0] DIP_CYC_MIN = 8'h02;

  typedef struct packed {
    logic [2:0] sup_sync;
    logic sup_low;
    logic dip_dis;
    logic [15:0] irq_en;
    logic [15:0] flags;
    logic irq_hold;
    logic [11:0] tmo_full;
    logic [11:0] tmo_cnt;
    logic [6:0] tmo_pre;
    logic tmo_active;
    logic [15:0] period;
    logic [15:0] per_cnt;
    logic [2:0] per_pre;
    logic zx;
    logic [7:0] dip_lvl;
    logic [7:0] dip_cyc;
    logic [7:0] dip_run;
    logic cyc_above;
    logic dip_active;
    logic [7:0] vpk_lvl;
    logic [7:0] ipk_lvl;
    logic [23:0] vmax;
    logic [23:0] imax;
    logic [23:0] rdata;
  } lem_state_t;

endpackage

/* tb/lem_monitor_asserts.sv */
// port checker for the line event monitor
`timescale 1ns/1ps
`default_nettype none
module lem_monitor_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic supply_low_i,
  input wire logic [15:0] volt_filt_i,
  input wire logic volt_filt_valid_i,
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_xfer_done_i,
  input wire logic [23:0] reg_rdata_o,
  input wire logic irq_n_o,
  input wire logic dip_n_o,
  input wire logic zero_cross_o,
  input wire logic inactive_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic clr_rd;
  logic in_xfer;
  assign clr_rd = reg_rd_i && reg_addr_i == lem_pkg::ADDR_STATUS_CLR;
  // open from clearing read until the last bit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) in_xfer <= 1'b0;
    else if (clr_rd) in_xfer <= 1'b1;
    else if (reg_xfer_done_i) in_xfer <= 1'b0;
  end
  rdata_stands_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  clr_irq_high_a: assert property (clr_rd |=> irq_n_o)
    else $error("irq low after clearing read");
  xfer_hold_a: assert property (in_xfer |-> irq_n_o)
    else $error("irq low during status transfer");
  supply_dip_a: assert property (inactive_o |-> !dip_n_o)
    else $error("dip output high while inactive");
  supply_sync_a: assert property (supply_low_i [*5] |-> inactive_o)
    else $error("supply low not reaching inactive");
  tmo_width_a: assert property (reg_rd_i && reg_addr_i == lem_pkg::ADDR_TMO
    |=> reg_rdata_o[23:12] == 12'h000) else $error("timeout value wider than 12 bits");
  period_msb_a: assert property (reg_rd_i && reg_addr_i == lem_pkg::ADDR_PERIOD
    |=> reg_rdata_o[23:15] == 9'h000) else $error("period top bit set");
  zx_sign_a: assert property (volt_filt_valid_i && volt_filt_i[15] |=> !zero_cross_o)
    else $error("zero cross high on negative voltage");
  cover property (clr_rd);
  cover property ($fell(dip_n_o));
  cover property ($fell(irq_n_o));
endmodule
bind lem_monitor lem_monitor_asserts u_chk (.clk_i, .rst_n_i, .supply_low_i, .volt_filt_i,
  .volt_filt_valid_i, .reg_addr_i, .reg_rd_i, .reg_xfer_done_i, .reg_rdata_o, .irq_n_o,
  .dip_n_o, .zero_cross_o, .inactive_o);
`default_nettype wire

/* tb/lem_host.sv */
// host model driving the register access port
`timescale 1ns/1ps
`default_nettype none
module lem_host (
  input wire logic clk_i,
  input wire logic [23:0] rdata_i,
  output logic [5:0] addr_o,
  output logic [23:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic done_o
);
  initial begin
    addr_o = 6'h00;
    wdata_o = 24'h000000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    done_o = 1'b0;
  end
  task automatic wr(input logic [5:0] a, input logic [23:0] v);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [23:0] v);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 v = rdata_i;
    // data bits take a few clocks to shift out
    repeat (3) @(posedge clk_i);
    done_o <= 1'b1;
    @(posedge clk_i);
    done_o <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

/* tb/lem_monitor_tb.sv */
// self-checking bench for the line event monitor
`timescale 1ns/1ps
`default_nettype none
module lem_monitor_tb;
  logic clk_i, rst_n_i, sup, fv, vv, cv, wr, rd, done, irq_n, dip_n, zx, inact;
  logic [15:0] vf;
  logic [23:0] vs, cs, wdata, rdata, d;
  logic [5:0] addr;
  int err_total, tests_run, n;
  lem_monitor uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .supply_low_i(sup),
    .volt_filt_i(vf), .volt_filt_valid_i(fv), .volt_sample_i(vs),
    .volt_sample_valid_i(vv), .curr_sample_i(cs), .curr_sample_valid_i(cv),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_xfer_done_i(done), .reg_rdata_o(rdata), .irq_n_o(irq_n),
    .dip_n_o(dip_n), .zero_cross_o(zx), .inactive_o(inact));
  lem_host h (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .done_o(done));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic end_of_test;
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic smp(input logic [23:0] v, input logic cur);
    @(posedge clk_i);
    if (cur) cs <= v;
    else vs <= v;
    cv <= cur;
    vv <= !cur;
    @(posedge clk_i);
    cv <= 1'b0;
    vv <= 1'b0;
    #1;
  endtask
  task automatic t_regs;
    h.rd(lem_pkg::ADDR_TMO, d); chk(d, 24'h000fff);
    h.wr(lem_pkg::ADDR_TMO, 24'h000123);
    h.rd(lem_pkg::ADDR_TMO, d); chk(d, 24'h000123);
    h.rd(6'h3f, d); chk(d, 24'h000000);
    h.wr(lem_pkg::ADDR_IRQ_EN, 24'h000300);
    h.rd(lem_pkg::ADDR_IRQ_EN, d); chk(d, 24'h000300);
  endtask
  task automatic t_peak;
    h.wr(lem_pkg::ADDR_VPK_LVL, 24'h000010);
    h.wr(lem_pkg::ADDR_IPK_LVL, 24'h000020);
    smp(24'hf00000, 1'b0); chk(24'(irq_n), 24'h0);
    smp(24'h080000, 1'b1);
    smp(24'h200000, 1'b1);
    h.rd(lem_pkg::ADDR_STATUS_CLR, d); chk(d, 24'h000300);
    chk(24'(irq_n), 24'h1);
    h.wr(lem_pkg::ADDR_IRQ_EN, 24'h000200);
    smp(24'h200000, 1'b1); chk(24'(irq_n), 24'h1);
    fork
      h.rd(lem_pkg::ADDR_STATUS_CLR, d);
      smp(24'h100000, 1'b0);
    join
    chk(d, 24'h000100);
    chk(24'(irq_n), 24'h0);
    h.rd(lem_pkg::ADDR_STATUS_CLR, d); chk(d, 24'h000200);
    h.rd(lem_pkg::ADDR_VMAX, d); chk(d, 24'h200000);
    h.rd(lem_pkg::ADDR_IMAX, d); chk(d, 24'h200000);
    h.rd(lem_pkg::ADDR_VMAX_CLR, d); chk(d, 24'h200000);
    h.rd(lem_pkg::ADDR_VMAX, d); chk(d, 24'h000000);
  endtask
  task automatic t_tmo;
    h.wr(lem_pkg::ADDR_TMO, 24'h000002);
    h.wr(lem_pkg::ADDR_IRQ_EN, 24'h000008);
    @(posedge clk_i);
    vf <= 16'h0100;
    @(posedge clk_i);
    vf <= 16'hff00;
    n = 0;
    while (dip_n !== 1'b0 && n < 600) begin
      @(posedge clk_i);
      #1 n++;
    end
    chk(24'(n > 127 && n < 300), 24'h1);
    chk(24'(irq_n), 24'h0);
    chk(24'(zx), 24'h0);
    h.rd(lem_pkg::ADDR_STATUS_CLR, d); chk(d, 24'h000018);
  endtask
  task automatic t_period;
    // 160-clock line cycle gives 20 ticks of 8 clocks
    repeat (5) begin
      @(posedge clk_i);
      vf <= 16'h0100;
      repeat (80) @(posedge clk_i);
      vf <= 16'hff00;
      repeat (79) @(posedge clk_i);
    end
    h.rd(lem_pkg::ADDR_PERIOD, d); chk(24'(d >= 19 && d <= 21), 24'h1);
  endtask
  task automatic t_dip;
    h.wr(lem_pkg::ADDR_DIP_CYC, 24'h000003);
    h.wr(lem_pkg::ADDR_DIP_LVL, 24'h000010);
    h.wr(lem_pkg::ADDR_IRQ_EN, 24'h000002);
    // small swing stays below the level; third rising crossing ends two full cycles
    repeat (2) begin
      @(posedge clk_i);
      vf <= 16'h0100;
      repeat (80) @(posedge clk_i);
      vf <= 16'hff00;
      repeat (79) @(posedge clk_i);
    end
    #1 chk(24'(irq_n), 24'h1);
    @(posedge clk_i);
    vf <= 16'h0100;
    @(posedge clk_i);
    #1 chk(24'(dip_n), 24'h0);
    chk(24'(irq_n), 24'h0);
    @(posedge clk_i);
    vf <= 16'h4000;
    @(posedge clk_i);
    #1 chk(24'(dip_n), 24'h1);
    h.rd(lem_pkg::ADDR_STATUS_CLR, d); chk(24'(d[1]), 24'h1);
  endtask
  task automatic t_supply;
    // timeout would also pull dip low; disable it so only supply can
    h.wr(lem_pkg::ADDR_MODE, 24'h000001);
    @(posedge clk_i);
    sup <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1 chk(24'(inact), 24'h1);
    chk(24'(dip_n), 24'h0);
    @(posedge clk_i);
    sup <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 chk(24'(inact), 24'h0);
    chk(24'(dip_n), 24'h1);
  endtask
  initial begin
    err_total = 0;
    tests_run = 0;
    {sup, vv, cv} = 3'h0;
    fv = 1'b1;
    vf = 16'hff00;
    vs = 24'h000000;
    cs = 24'h000000;
    rst_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_peak;
    t_tmo;
    t_period;
    t_dip;
    t_supply;
    end_of_test;
  end
  initial begin
    #(5000 * 100);
    err_total++;
    end_of_test;
  end
endmodule
`default_nettype wire
